// ===== inc/lsf_pkg.sv
// lsf_pkg: constants and types of the lin slave frame handler
// assumes a byte-level receiver/transmitter on mclk below the handler
// Contract
// - bit error flag, status bit 0, when a sent bit differs from bus
// - header error flag, status bit 1, on identifier parity or sync error
// - data error flag, status bit 2, on checksum, stop bit or length error
// - time-out flag, status bit 3, frame not done in time; bits 7-4 zero
// - full status read command clears all error flags
// - node address is 7 bits: 4 otp bits plus 3 hardwired pins
// - otp mode bit selects how otp and pin bits are arranged
// - frame is identifier, 2/4/8 data bytes, then one checksum byte
// - checksum is inverted 8-bit carry-wrapped sum over data bytes only
// - identifier bits 6 and 7 are parity bits; mismatch is header error
// - general purpose write: byte 1 command, byte 2 broadcast bit and address
// - identifier bits 5:4 give length: 00/01 two, 10 four, 11 eight
// - application-bound dynamic writes act regardless of node address
// - node-bound two byte dynamic writes are accepted
// - id 0x3C eight byte write: marker, command, address, parameters
// - read frame: master sends header, one slave sends data and checksum
// - direct read identifier only triggers the read, nothing else
// - indirect read answered only right after a preparing frame to us
// - every read response carries own node address
// - direct read answered without preparing frame, 2/4/8 bytes
// - id 0x3D is indirect eight byte read needing a preparing frame
// - ids 0x3C and 0x3F never match as dynamic identifiers
package lsf_pkg;

	localparam int         CLK_MHZ       = 100;                     // mclk rate
	localparam int         FRAME_MAX_US  = 18084;                   // 8 byte frame at 9.6 kbit/s
	localparam int         FRAME_MAX_CYC = FRAME_MAX_US * CLK_MHZ;  // exact integer product, no rounding
	localparam logic [5:0] ID_CMD_WR     = 6'h3C;                   // reserved command write
	localparam logic [5:0] ID_RD_IND     = 6'h3D;                   // reserved indirect read
	localparam logic [5:0] ID_EXT        = 6'h3F;                   // reserved extended frame
	localparam logic [7:0] APP_CMD_MARK  = 8'h80;                   // app_command_marker value
	localparam logic [6:0] CMD_FULL_STAT = 7'h01;                   // full_status_read_cmd code
	localparam logic [3:0] LEN_2         = 4'h2;
	localparam logic [3:0] LEN_4         = 4'h4;
	localparam logic [3:0] LEN_8         = 4'h8;
	localparam int         ERR_BIT       = 0;                       // status bit positions
	localparam int         ERR_HDR       = 1;
	localparam int         ERR_DATA      = 2;
	localparam int         ERR_TOUT      = 3;
	localparam logic [7:0] ERR_RESET     = 8'h00;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ID   = 5'h02,
		ST_RX   = 5'h04,
		ST_TX   = 5'h08,
		ST_SKIP = 5'h10
	} lsf_state_e;

	typedef enum logic [2:0] {
		KIND_GP    = 3'h0,  // general purpose, command in byte 1
		KIND_APP   = 3'h1,  // id bound to a command
		KIND_NODE  = 3'h2,  // id bound to node and command
		KIND_CMD3C = 3'h3,  // reserved command write
		KIND_PREP  = 3'h4   // two byte preparing frame
	} lsf_kind_e;

endpackage

// ===== logic/lsf_cksum.sv
// lsf_cksum: running carry-wrapped byte sum
// assumes clr and add are never high together with meaningful add
`timescale 1ns/1ps
`default_nettype none
module lsf_cksum
	import lsf_pkg::*;
(
	input  wire logic       mclk,     // system clock
	input  wire logic       rstn,     // sync reset, low
	input  wire logic       clr,      // restart sum
	input  wire logic       add,      // accumulate add_byte
	input  wire logic [7:0] add_byte, // byte to add
	output logic      [7:0] sum_reg   // current sum, not inverted
);

	logic [8:0] wide;
	logic [7:0] sum_next;

	// carry goes back into bit 0, so the result never overflows
	assign wide     = {1'b0, sum_reg} + {1'b0, add_byte};
	assign sum_next = wide[7:0] + {7'h00, wide[8]};

	always_ff @(posedge mclk) begin
		if (!rstn || clr) begin
			sum_reg <= 8'h00;
		end else if (add) begin
			sum_reg <= sum_next;
		end
	end

endmodule // lsf_cksum

`default_nettype wire

// ===== logic/lsf_node_addr.sv
// lsf_node_addr: forms the 7-bit node address
// assumes otp bits are static levels on mclk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module lsf_node_addr
	import lsf_pkg::*;
(
	input  wire logic       mclk,                   // system clock
	input  wire logic       rstn,                   // sync reset, low
	input  wire logic [2:0] hardwired_addr_pins,    // board straps
	input  wire logic [3:0] otp_addr_bits,          // programmed bits
	input  wire logic       address_combine_select, // otp mode bit
	output logic      [6:0] node_addr_reg           // combined address
);

	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] s3_reg;
	logic [2:0] pins_reg;

	// three stages; a strap change counts only once stages two and three agree
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			s1_reg   <= 3'h0;
			s2_reg   <= 3'h0;
			s3_reg   <= 3'h0;
			pins_reg <= 3'h0;
		end else begin
			s1_reg <= hardwired_addr_pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				pins_reg <= s3_reg;
			end
		end
	end

	// mode bit picks where the pin bits sit inside the address
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			node_addr_reg <= 7'h00;
		end else if (address_combine_select) begin
			node_addr_reg <= {pins_reg[2], otp_addr_bits, pins_reg[1:0]};
		end else begin
			node_addr_reg <= {otp_addr_bits, pins_reg};
		end
	end

endmodule // lsf_node_addr

`default_nettype wire

// ===== logic/lsf_frame_handler.sv
// lsf_frame_handler: frame layer of a lin slave node
// assumes a byte layer on mclk that strips break and sync, flags sync,
// stop and bit faults as pulses, and does not echo own bytes on rx_valid
`timescale 1ns/1ps
`default_nettype none
module lsf_frame_handler
	import lsf_pkg::*;
#(
	parameter int FRAME_MAX_CYCLES = FRAME_MAX_CYC // frame time-out in cycles
) (
	input  wire logic        mclk,                   // system clock
	input  wire logic        rstn,                   // sync reset, low
	input  wire logic        rx_hdr_start,           // break and sync seen
	input  wire logic        rx_sync_err,            // bad sync field
	input  wire logic        rx_valid,               // rx_byte valid
	input  wire logic [7:0]  rx_byte,                // received byte
	input  wire logic        rx_stop_err,            // bad stop bit
	input  wire logic        tx_bit_err,             // sent bit differs from bus
	input  wire logic        tx_ready,               // byte layer takes tx_byte
	input  wire logic [2:0]  hardwired_addr_pins,    // address straps
	input  wire logic [3:0]  otp_addr_bits,          // address otp bits
	input  wire logic        address_combine_select, // otp address mode
	input  wire logic [5:0]  dyn_gp2_id,             // general purpose 2 byte id
	input  wire logic [5:0]  dyn_gp4_id,             // general purpose 4 byte id
	input  wire logic [5:0]  dyn_app_id,             // command-bound id
	input  wire logic [5:0]  dyn_node_id,            // node-bound id
	input  wire logic [5:0]  dyn_prep_id,            // preparing frame id
	input  wire logic [5:0]  dyn_read_id,            // direct read id
	input  wire logic [63:0] rd_data,                // response bytes, byte k at 8k
	output logic             tx_valid,               // tx_byte offered
	output logic      [7:0]  tx_byte,                // byte to send
	output logic             cmd_valid,              // accepted write, pulse
	output lsf_kind_e        cmd_kind,               // frame kind of write
	output logic      [6:0]  cmd_code,               // command code
	output logic      [3:0]  cmd_len,                // data byte count
	output logic      [63:0] cmd_data,               // data bytes, byte 0 low
	output logic             rd_req,                 // read started, pulse
	output logic      [6:0]  rd_cmd,                 // prepared command
	output logic             rd_direct,              // read came from direct id
	output logic      [3:0]  rd_len,                 // response data bytes
	output logic      [7:0]  link_error_status,      // error flags
	output logic      [6:0]  node_addr               // own address
);

	lsf_state_e state_reg;
	lsf_kind_e  kind_reg;
	lsf_kind_e  dec_kind;
	logic [3:0]  idx_reg;
	logic [3:0]  len_reg;
	logic [7:0]  data_reg [0:7];
	logic        bad_reg;
	logic        prep_armed_reg;
	logic [6:0]  prep_cmd_reg;
	logic [31:0] tout_cnt_reg;
	logic [5:0]  id6;
	logic        par_ok;
	logic        reserved_id;
	logic [3:0]  id_len;
	logic [3:0]  dec_len;
	logic        dec_take;
	logic        dec_read;
	logic        id_seen;
	logic        rx_data_add;
	logic        rx_ck_byte;
	logic        tx_acc;
	logic        tx_data_acc;
	logic        cks_ok;
	logic        exec_ok;
	logic        do_cmd;
	logic        do_prep;
	logic [6:0]  exec_code;
	logic [7:0]  ck_sum;
	logic [7:0]  resp_byte;
	logic        tout_hit;
	logic        counting;
	logic        len_err;
	logic        clr_err;
	logic [7:0]  err_set;

	lsf_node_addr u_addr (
		.mclk                   (mclk),
		.rstn                   (rstn),
		.hardwired_addr_pins    (hardwired_addr_pins),
		.otp_addr_bits          (otp_addr_bits),
		.address_combine_select (address_combine_select),
		.node_addr_reg          (node_addr)
	);

	// one sum serves receive checking and transmit generation
	lsf_cksum u_cks (
		.mclk     (mclk),
		.rstn     (rstn),
		.clr      (id_seen),
		.add      (rx_data_add | tx_data_acc),
		.add_byte (tx_data_acc ? tx_byte : rx_byte),
		.sum_reg  (ck_sum)
	);

	// identifier checks
	assign id6         = rx_byte[5:0];
	assign par_ok      = (rx_byte[6] == ^{rx_byte[4], rx_byte[2:0]})
	                  && (rx_byte[7] == ~^{rx_byte[5:3], rx_byte[1]});
	assign reserved_id = (id6 == ID_CMD_WR) || (id6 == ID_EXT) || (id6 == ID_RD_IND);
	assign id_seen     = (state_reg == ST_ID) && rx_valid && !rx_hdr_start;

	// length from the two upper identifier bits
	always_comb begin
		case (rx_byte[5:4])
			2'b11:   id_len = LEN_8;
			2'b10:   id_len = LEN_4;
			default: id_len = LEN_2;
		endcase
	end

	// reserved ids are checked first so they can never alias a dynamic id
	always_comb begin
		dec_kind = KIND_APP;
		dec_len  = id_len;
		dec_take = 1'b1;
		dec_read = 1'b0;
		if (id6 == ID_CMD_WR) begin
			dec_kind = KIND_CMD3C;
			dec_len  = LEN_8;
		end else if (id6 == ID_RD_IND) begin
			dec_read = 1'b1;
			dec_len  = LEN_8;
			dec_take = prep_armed_reg;
		end else if (reserved_id) begin
			dec_take = 1'b0;
		end else if (id6 == dyn_prep_id) begin
			dec_kind = KIND_PREP;
		end else if (id6 == dyn_gp2_id || id6 == dyn_gp4_id) begin
			dec_kind = KIND_GP;
		end else if (id6 == dyn_node_id) begin
			dec_kind = KIND_NODE;
		end else if (id6 == dyn_app_id) begin
			dec_kind = KIND_APP;
		end else if (id6 == dyn_read_id) begin
			dec_read = 1'b1;
		end else begin
			dec_take = 1'b0;
		end
	end

	// byte strobes
	assign rx_data_add = (state_reg == ST_RX) && rx_valid && !rx_hdr_start && (idx_reg < len_reg);
	assign rx_ck_byte  = (state_reg == ST_RX) && rx_valid && !rx_hdr_start && (idx_reg == len_reg);
	assign tx_acc      = (state_reg == ST_TX) && tx_valid && tx_ready;
	assign tx_data_acc = tx_acc && (idx_reg < len_reg);
	assign cks_ok      = (rx_byte == ~ck_sum);
	assign exec_ok     = rx_ck_byte && cks_ok && !bad_reg;

	// what an intact writing frame does
	always_comb begin
		do_cmd    = 1'b0;
		do_prep   = 1'b0;
		exec_code = 7'h00;
		case (kind_reg)
			KIND_GP: begin
				do_cmd    = !data_reg[1][7] || (data_reg[1][6:0] == node_addr);
				exec_code = data_reg[0][6:0];
			end
			KIND_APP, KIND_NODE: begin
				do_cmd = 1'b1;
			end
			KIND_PREP: begin
				do_prep   = data_reg[1][6:0] == node_addr;
				exec_code = data_reg[0][6:0];
			end
			KIND_CMD3C: begin
				do_cmd    = (data_reg[0] == APP_CMD_MARK)
				         && (!data_reg[2][7] || (data_reg[2][6:0] == node_addr));
				do_prep   = (data_reg[0] == APP_CMD_MARK) && (data_reg[2][6:0] == node_addr);
				exec_code = data_reg[1][6:0];
			end
			default: begin
				do_cmd = 1'b0;
			end
		endcase
	end

	// response byte 0 always carries the own address
	always_comb begin
		if (idx_reg == 4'h0) begin
			resp_byte = {1'b1, node_addr};
		end else if (idx_reg == 4'h1 && !rd_direct && rd_cmd == CMD_FULL_STAT) begin
			resp_byte = link_error_status;
		end else begin
			resp_byte = rd_data[{idx_reg[2:0], 3'b000} +: 8];
		end
	end

	// frame sequencing; a new header always restarts
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
		end else if (tout_hit) begin
			state_reg <= ST_IDLE;
		end else if (rx_hdr_start) begin
			state_reg <= ST_ID;
		end else begin
			case (state_reg)
				ST_ID: begin
					if (rx_valid) begin
						if (!par_ok || !dec_take) begin
							state_reg <= ST_SKIP;
						end else if (dec_read) begin
							state_reg <= ST_TX;
						end else begin
							state_reg <= ST_RX;
						end
					end
				end
				ST_RX: begin
					if (rx_ck_byte) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_TX: begin
					if (tx_bit_err) begin
						state_reg <= ST_SKIP;
					end else if (tx_acc && idx_reg == len_reg) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_IDLE, ST_SKIP: begin
					state_reg <= state_reg;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// byte index, length and kind of the current frame
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			idx_reg  <= 4'h0;
			len_reg  <= LEN_2;
			kind_reg <= KIND_APP;
		end else if (id_seen) begin
			idx_reg  <= 4'h0;
			len_reg  <= dec_len;
			kind_reg <= dec_kind;
		end else if (rx_data_add || tx_acc) begin
			idx_reg <= idx_reg + 4'h1;
		end
	end

	// data bytes; a stop fault before the checksum byte taints the whole frame
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			bad_reg <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				data_reg[i] <= 8'h00;
			end
		end else begin
			if (id_seen) begin
				bad_reg <= 1'b0;
			end else if (state_reg == ST_RX && rx_stop_err) begin
				bad_reg <= 1'b1;
			end
			if (rx_data_add) begin
				data_reg[idx_reg[2:0]] <= rx_byte;
			end
		end
	end

	// preparing state lives for exactly the next header
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			prep_armed_reg <= 1'b0;
			prep_cmd_reg   <= 7'h00;
		end else if (exec_ok && do_prep) begin
			prep_armed_reg <= 1'b1;
			prep_cmd_reg   <= exec_code;
		end else if (id_seen) begin
			prep_armed_reg <= 1'b0;
		end
	end

	// command hand-off to the application
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cmd_valid <= 1'b0;
			cmd_kind  <= KIND_APP;
			cmd_code  <= 7'h00;
			cmd_len   <= LEN_2;
			cmd_data  <= 64'h0000_0000_0000_0000;
		end else begin
			cmd_valid <= exec_ok && do_cmd;
			if (exec_ok && do_cmd) begin
				cmd_kind <= kind_reg;
				cmd_code <= exec_code;
				cmd_len  <= len_reg;
				for (int i = 0; i < 8; i++) begin
					cmd_data[i*8 +: 8] <= data_reg[i];
				end
			end
		end
	end

	// read request; a direct id does nothing but start the response
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			rd_req    <= 1'b0;
			rd_cmd    <= 7'h00;
			rd_direct <= 1'b0;
			rd_len    <= LEN_2;
		end else begin
			rd_req <= id_seen && par_ok && dec_take && dec_read;
			if (id_seen && par_ok && dec_take && dec_read) begin
				rd_direct <= id6 != ID_RD_IND;
				rd_cmd    <= (id6 == ID_RD_IND) ? prep_cmd_reg : 7'h00;
				rd_len    <= dec_len;
			end
		end
	end

	// transmit one byte at a time, checksum last
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			tx_valid <= 1'b0;
			tx_byte  <= 8'h00;
		end else if (state_reg != ST_TX || rx_hdr_start || tx_bit_err || tout_hit || tx_acc) begin
			tx_valid <= 1'b0;
		end else if (!tx_valid) begin
			tx_valid <= 1'b1;
			tx_byte  <= (idx_reg == len_reg) ? ~ck_sum : resp_byte;
		end
	end

	// frame time-out counts every header up to its identifier, then only frames this node takes part in
	assign counting = (state_reg == ST_ID) || (state_reg == ST_RX) || (state_reg == ST_TX);
	assign tout_hit = counting && !rx_hdr_start && (tout_cnt_reg == 32'(FRAME_MAX_CYCLES - 1));

	always_ff @(posedge mclk) begin
		if (!rstn || rx_hdr_start || !counting) begin
			tout_cnt_reg <= 32'h0000_0000;
		end else begin
			tout_cnt_reg <= tout_cnt_reg + 32'h0000_0001;
		end
	end

	// a header cutting into a frame means the frame was too short
	assign len_err = rx_hdr_start && (state_reg == ST_RX || state_reg == ST_TX);
	assign clr_err = tx_acc && (idx_reg == len_reg) && !rd_direct && (rd_cmd == CMD_FULL_STAT);

	always_comb begin
		err_set           = 8'h00;
		err_set[ERR_BIT]  = tx_bit_err;
		err_set[ERR_HDR]  = rx_sync_err || (id_seen && !par_ok);
		err_set[ERR_DATA] = (rx_stop_err && state_reg == ST_RX) || (rx_ck_byte && !cks_ok) || len_err;
		err_set[ERR_TOUT] = tout_hit;
	end

	// sticky flags; a new fault in the clearing cycle survives
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			link_error_status <= ERR_RESET;
		end else if (clr_err) begin
			link_error_status <= err_set;
		end else begin
			link_error_status <= link_error_status | err_set;
		end
	end

endmodule // lsf_frame_handler

`default_nettype wire

// ===== tb/lsf_frame_handler_chk.sv
// lsf_frame_handler_chk: port-level checks of the lin slave frame handler
// assumes one mclk domain and rstn synchronous, active low
`timescale 1ns/1ps
`default_nettype none
module lsf_frame_handler_chk #(
	parameter int FRAME_MAX_CYCLES = 200 // kept in step with the design
) (
	input wire logic       mclk,                   // system clock
	input wire logic       rstn,                   // sync reset, low
	input wire logic       rx_valid,               // byte strobe
	input wire logic       rx_sync_err,            // sync fault
	input wire logic       tx_bit_err,             // bit fault
	input wire logic       tx_ready,               // byte layer accepts
	input wire logic [2:0] hardwired_addr_pins,    // straps
	input wire logic [3:0] otp_addr_bits,          // otp bits
	input wire logic       address_combine_select, // otp mode
	input wire logic       tx_valid,               // byte offered
	input wire logic [7:0] tx_byte,                // byte sent
	input wire logic       cmd_valid,              // write pulse
	input wire logic       rd_req,                 // read pulse
	input wire logic [7:0] link_error_status,      // flags
	input wire logic [6:0] node_addr               // own address
);
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic [6:0] want_addr;
	// mode 1 lifts the top strap above the otp bits
	assign want_addr = address_combine_select ? {hardwired_addr_pins[2], otp_addr_bits, hardwired_addr_pins[1:0]}
		: {otp_addr_bits, hardwired_addr_pins};
	a_status_upper: assert property (link_error_status[7:4] == 4'h0)
		else $error("status upper bits not zero");
	a_bit_flag: assert property (tx_bit_err |=> link_error_status[0])
		else $error("bit error flag missing");
	a_sync_flag: assert property (rx_sync_err |=> link_error_status[1])
		else $error("header error flag missing");
	a_flag_clear: assert property ((|($past(link_error_status) & ~link_error_status)) |-> $past(tx_valid && tx_ready))
		else $error("flag dropped outside a response");
	a_cmd_timing: assert property (cmd_valid |-> $past(rx_valid))
		else $error("write accepted without a checksum byte");
	a_rd_timing: assert property (rd_req |-> $past(rx_valid))
		else $error("read started without identifier");
	a_addr_first: assert property (rd_req |=> (tx_valid && tx_byte == {1'b1, node_addr}))
		else $error("response does not open with node address");
	a_tx_hold: assert property (tx_valid && !tx_ready && !tx_bit_err |=> tx_valid && $stable(tx_byte))
		else $error("offered byte withdrawn");
	a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("no idle cycle after accepted byte");
	// straps pass a sync chain, so the address lags a change by a few edges
	a_node_addr: assert property (($stable(hardwired_addr_pins) && $stable(otp_addr_bits)
		&& $stable(address_combine_select)) [*8] |-> node_addr == want_addr)
		else $error("node address combination wrong");
	a_write_silent: assert property (cmd_valid |-> !tx_valid)
		else $error("write frame answered");
	c_write: cover property (cmd_valid);
	c_read: cover property (rd_req ##1 tx_valid);
	c_all_flags: cover property (link_error_status == 8'h0F);
endmodule // lsf_frame_handler_chk
bind lsf_frame_handler lsf_frame_handler_chk #(.FRAME_MAX_CYCLES(FRAME_MAX_CYCLES)) u_chk (.mclk(mclk), .rstn(rstn),
	.rx_valid(rx_valid), .rx_sync_err(rx_sync_err), .tx_bit_err(tx_bit_err), .tx_ready(tx_ready),
	.hardwired_addr_pins(hardwired_addr_pins), .otp_addr_bits(otp_addr_bits),
	.address_combine_select(address_combine_select), .tx_valid(tx_valid), .tx_byte(tx_byte),
	.cmd_valid(cmd_valid), .rd_req(rd_req), .link_error_status(link_error_status), .node_addr(node_addr));
`default_nettype wire

// ===== tb/lsf_master_model.sv
// lsf_master_model: lin master seen through the slave's byte layer
// assumes the bench calls its tasks; bytes go out 4 cycles apart
`timescale 1ns/1ps
`default_nettype none
module lsf_master_model (
	input  wire logic       mclk,         // system clock
	input  wire logic       tx_valid,     // slave offers a byte
	output logic            rx_hdr_start, // header pulse
	output logic            rx_sync_err,  // sync fault pulse
	output logic            rx_valid,     // byte pulse
	output logic      [7:0] rx_byte,      // byte to slave
	output logic            rx_stop_err,  // stop fault pulse
	output logic            tx_bit_err,   // bit fault pulse
	output logic            tx_ready      // byte layer accepts
);
	int seed = 78;
	initial begin
		{rx_hdr_start, rx_sync_err, rx_valid, rx_stop_err, tx_bit_err} = '0;
		rx_byte = 8'h00;
	end
	// random stalls on the response path, far kinder than a slow line
	always @(posedge mclk) tx_ready <= #1 $random(seed) & 1;
	function automatic logic [7:0] pid(input logic [5:0] id);
		return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
	endfunction
	function automatic logic [7:0] cks(input int n, input logic [63:0] d);
		logic [8:0] s;
		s = 9'h000;
		for (int k = 0; k < n; k++) s = {1'b0, s[7:0]} + d[8*k +: 8] + s[8];
		s = {1'b0, s[7:0]} + s[8];
		return ~s[7:0];
	endfunction
	// one byte or header; err marks the sync field or the stop bit as bad
	task automatic put(input logic hdr, input logic [7:0] b, input logic err);
		@(posedge mclk); #1;
		rx_hdr_start = hdr; rx_valid = !hdr; rx_byte = b; rx_sync_err = err && hdr; rx_stop_err = err && !hdr;
		@(posedge mclk); #1;
		{rx_hdr_start, rx_valid, rx_sync_err, rx_stop_err} = '0;
		rx_byte = ~b; // released line does not keep the last value
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic hd(input logic [5:0] id, input logic bad, input logic serr);
		put(1'b1, 8'h55, serr);
		put(1'b0, pid(id) ^ {bad, 7'h00}, 1'b0);
	endtask
	task automatic wr(input logic [5:0] id, input int n, input logic [63:0] d, input logic bad);
		hd(id, 1'b0, 1'b0);
		for (int k = 0; k < n; k++) put(1'b0, d[8*k +: 8], 1'b0);
		put(1'b0, cks(n, d) ^ {7'h00, bad}, 1'b0);
	endtask
	task automatic berr();
		@(posedge mclk); #1;
		tx_bit_err = 1'b1;
		@(posedge mclk); #1;
		tx_bit_err = 1'b0;
	endtask
endmodule // lsf_master_model
`default_nettype wire

// ===== tb/test_lin_slave_frame_handler.sv
// test_lin_slave_frame_handler: self-checking bench of the frame handler
// assumes the master model and the bound checker; short frame time-out
`timescale 1ns/1ps
`default_nettype none
module test_lin_slave_frame_handler;
	import lsf_pkg::*;
	localparam int TMO = 200;
	logic mclk, rstn, hs, se, rv, ste, be, tr, mode, tv, cv, rq, rdir;
	logic [7:0] rb, tb_, st, est;
	logic [2:0] pins;
	logic [3:0] otp, cl, rl;
	logic [5:0] i_gp2, i_gp4, i_app, i_node, i_prep, i_rd;
	logic [63:0] rdat, cd, d, msk;
	logic [6:0] cc, rc, me;
	lsf_kind_e ck;
	int seed, mismatches, comparisons, ncmd, c0, k, n, t;
	logic [31:0] r;
	lsf_master_model u_mst (.mclk(mclk), .tx_valid(tv), .rx_hdr_start(hs), .rx_sync_err(se), .rx_valid(rv),
		.rx_byte(rb), .rx_stop_err(ste), .tx_bit_err(be), .tx_ready(tr));
	lsf_frame_handler #(.FRAME_MAX_CYCLES(TMO)) u_dut (.mclk(mclk), .rstn(rstn), .rx_hdr_start(hs),
		.rx_sync_err(se), .rx_valid(rv), .rx_byte(rb), .rx_stop_err(ste), .tx_bit_err(be), .tx_ready(tr),
		.hardwired_addr_pins(pins), .otp_addr_bits(otp), .address_combine_select(mode), .dyn_gp2_id(i_gp2),
		.dyn_gp4_id(i_gp4), .dyn_app_id(i_app), .dyn_node_id(i_node), .dyn_prep_id(i_prep), .dyn_read_id(i_rd),
		.rd_data(rdat), .tx_valid(tv), .tx_byte(tb_), .cmd_valid(cv), .cmd_kind(ck), .cmd_code(cc), .cmd_len(cl),
		.cmd_data(cd), .rd_req(rq), .rd_cmd(rc), .rd_direct(rdir), .rd_len(rl), .link_error_status(st),
		.node_addr(me));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// counts accepted writes so dropped frames show as no change
	always @(posedge mclk) if (cv === 1'b1) ncmd <= ncmd + 1;
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// collects n data bytes and the checksum at the accepting edges
	task automatic resp(input int n, input logic [63:0] e);
		for (int j = 0; j <= n; j++) begin
			t = 0;
			do begin
				@(negedge mclk);
				t++;
			end while (!(tv === 1'b1 && tr === 1'b1) && t < 100);
			if (t >= 100) begin
				mismatches++;
				conclude();
			end
			chk("response byte", tb_, j < n ? e[8*j +: 8] : u_mst.cks(n, e));
		end
	endtask
	initial begin
		seed = 78;
		{mismatches, comparisons, ncmd} = '0;
		rstn = 1'b0;
		r = $random(seed);
		// dynamic table drawn per run; the top nibbles keep every entry distinct
		{i_gp2, i_node, i_prep} = {4'h0, r[1:0], 4'h1, r[3:2], 4'h4, r[5:4]};
		{i_gp4, i_rd, i_app} = {4'h8, r[7:6], 4'h9, r[9:8], 4'hC, r[11:10]};
		{pins, otp, mode} = r[19:12];
		rdat = {$random(seed), $random(seed)};
		repeat (5) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (8) @(posedge mclk);
		#1 chk("status", st, ERR_RESET);
		chk("node addr", me, mode ? {pins[2], otp, pins[1:0]} : {otp, pins});
		$display("reset and address done");
		for (int i = 0; i < 12; i++) begin
			k = $random(seed) & 3;
			d = {$random(seed), $random(seed)};
			d[7] = 1'b1;
			if ($random(seed) & 1) d[14:8] = me;
			n = k == 1 ? 4 : (k == 2 ? 8 : 2);
			msk = n == 8 ? '1 : (64'h1 << (8 * n)) - 1;
			c0 = ncmd;
			u_mst.wr(k == 0 ? i_gp2 : (k == 1 ? i_gp4 : (k == 2 ? i_app : i_node)), n, d, 1'b0);
			chk("accepted", ncmd - c0, k > 1 || !d[15] || d[14:8] == me);
			if (ncmd != c0) begin
				chk("kind", ck, k < 2 ? KIND_GP : (k == 2 ? KIND_APP : KIND_NODE));
				chk("len", cl, n);
				chk("code", cc, k < 2 ? d[6:0] : 7'h00);
				chk("data", cd & msk, d & msk);
			end
		end
		d = {$random(seed), $random(seed)};
		d[23:0] = {1'b1, me, 1'b1, d[14:8], APP_CMD_MARK};
		u_mst.wr(ID_CMD_WR, 8, d, 1'b0);
		chk("cmd3c kind", ck, KIND_CMD3C);
		chk("cmd3c code", cc, d[14:8]);
		c0 = ncmd;
		u_mst.wr(ID_EXT, 8, d, 1'b0);
		u_mst.wr(i_gp2, 2, {48'h0, 1'b0, me, 8'h85}, 1'b1);
		chk("dropped", ncmd - c0, 0);
		est = 8'h04;
		chk("status", st, est);
		u_mst.hd(i_gp2, 1'b1, 1'b0);
		est = 8'h06;
		chk("status", st, est);
		$display("write frames done");
		fork
			u_mst.hd(i_rd, 1'b0, 1'b0);
			resp(4, {rdat[31:8], 1'b1, me});
		join
		chk("direct", rdir, 1'b1);
		chk("rd len", rl, 4);
		chk("no write", ncmd - c0, 0);
		u_mst.hd(i_rd, 1'b0, 1'b0);
		repeat (3) @(posedge mclk);
		u_mst.berr();
		repeat (20) @(posedge mclk);
		#1 est = 8'h07;
		chk("status", st, est);
		u_mst.hd(i_gp4, 1'b0, 1'b1);
		u_mst.hd(i_gp4, 1'b0, 1'b0);
		u_mst.put(1'b0, 8'h81, 1'b0);
		repeat (TMO + 10) @(posedge mclk);
		#1 est = 8'h0F;
		chk("status", st, est);
		$display("error flags done");
		u_mst.hd(ID_RD_IND, 1'b0, 1'b0);
		t = 0;
		repeat (12) @(negedge mclk) if (tv === 1'b1) t++;
		chk("unprepared reply", t, 0);
		u_mst.wr(i_prep, 2, {48'h0, 1'b1, me, 1'b1, CMD_FULL_STAT}, 1'b0);
		fork
			u_mst.hd(ID_RD_IND, 1'b0, 1'b0);
			resp(8, {rdat[63:16], est, 1'b1, me});
		join
		chk("rd cmd", rc, CMD_FULL_STAT);
		repeat (3) @(posedge mclk);
		#1 chk("status cleared", st, 8'h00);
		$display("reading frames done");
		conclude();
	end
endmodule // test_lin_slave_frame_handler
`default_nettype wire
